/* inc/ante_pkg.sv */
`default_nettype none
package ante_pkg;
	localparam int CNT_W = 5;
	localparam int PBI_W = 4;
	localparam int GAP_W = 4;
	localparam int TA_W = 4;
	localparam int POS_W = 8;
	localparam int WORDS_W = 3;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int BE_W = 2;
	localparam int NUM_CS = 8;
	localparam int SEL_W = 3;
	localparam int NUM_WAIT = 4;
	localparam int SAMPLE_PIPE = 3;
	localparam int NUM_STB = 5;
	localparam int STB_CS = 0;
	localparam int STB_LATCH = 1;
	localparam int STB_RD = 2;
	localparam int STB_WR = 3;
	localparam int STB_DIR = 4;
	localparam logic [POS_W-1:0] POS_ONE = 8'h01;
	localparam logic [GAP_W-1:0] GAP_ONE = 4'h1;
	localparam logic [TA_W-1:0] TA_ONE = 4'h1;
	localparam logic [NUM_CS-1:0] CS_ONE = 8'h01;
	localparam logic [WORDS_W-1:0] WORD_ONE = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h0000000;

	typedef struct packed {
		logic [CNT_W-1:0] select_assert_count;
		logic [CNT_W-1:0] select_read_release_count;
		logic [CNT_W-1:0] select_write_release_count;
		logic [CNT_W-1:0] latch_assert_count;
		logic [CNT_W-1:0] latch_read_release_count;
		logic [CNT_W-1:0] latch_write_release_count;
		logic [CNT_W-1:0] read_strobe_assert_count;
		logic [CNT_W-1:0] read_strobe_release_count;
		logic [CNT_W-1:0] write_strobe_assert_count;
		logic [CNT_W-1:0] write_strobe_release_count;
		logic [CNT_W-1:0] read_cycle_length;
		logic [CNT_W-1:0] write_cycle_length;
		logic [CNT_W-1:0] sample_delay_count;
		logic [PBI_W-1:0] page_word_interval;
		logic timing_scale_bit;
		logic select_half_cycle_shift;
		logic latch_half_cycle_shift;
		logic read_strobe_half_cycle_shift;
		logic write_strobe_half_cycle_shift;
		logic [GAP_W-1:0] inter_access_gap;
		logic [TA_W-1:0] turnaround_count;
	} ante_timing_s;

	typedef struct packed {
		logic write;
		logic [SEL_W-1:0] sel;
		logic [ADDR_W-1:0] addr;
		logic [BE_W-1:0] be_n;
		logic [DATA_W-1:0] wdata;
		logic [WORDS_W-1:0] words_m1;
	} ante_req_s;

	typedef enum logic [1:0] {
		ANTE_IDLE,
		ANTE_ACCESS,
		ANTE_GAP
	} ante_state_e;
endpackage
`default_nettype wire

/* core/ante_timing_engine.sv */
`timescale 1ns/1ns
`default_nettype none
module ante_timing_engine (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ante_pkg::ante_timing_s cfg,
	input wire logic req_valid,
	output logic req_ready,
	input wire ante_pkg::ante_req_s req,
	input wire logic [ante_pkg::DATA_W-1:0] burst_wdata,
	output logic wr_word_take,
	output logic rd_valid,
	output logic [ante_pkg::DATA_W-1:0] rd_data,
	output logic busy,
	output logic [ante_pkg::NUM_WAIT-1:0] wait_level,
	output logic [ante_pkg::ADDR_W-1:0] mem_addr,
	output logic mem_addr_valid,
	output logic [ante_pkg::BE_W-1:0] mem_be_n,
	output logic [ante_pkg::DATA_W-1:0] mem_dout,
	output logic mem_dout_oe,
	input wire logic [ante_pkg::DATA_W-1:0] mem_din,
	input wire logic [ante_pkg::NUM_WAIT-1:0] mem_wait_in,
	output logic [ante_pkg::NUM_CS-1:0] cs_n,
	output logic latch_n,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	output logic io_dir
);
	localparam int PW = ante_pkg::POS_W;

	ante_pkg::ante_state_e state_q;
	ante_pkg::ante_state_e state_d;
	ante_pkg::ante_req_s req_q;
	logic [PW-1:0] u_q;
	logic s_q;
	logic [ante_pkg::WORDS_W-1:0] word_q;
	logic [PW-1:0] next_q;
	logic [ante_pkg::GAP_W-1:0] gap_q;
	logic [ante_pkg::TA_W-1:0] ta_q;
	logic [ante_pkg::NUM_STB-1:0] stb_pos_q;
	logic [ante_pkg::NUM_STB-1:0] stb_neg_q;
	logic [ante_pkg::NUM_STB-1:0] stb_d;
	logic [ante_pkg::SAMPLE_PIPE-1:0] samp_pipe_q;
	logic [ante_pkg::DATA_W-1:0] din_s1_q;
	logic [ante_pkg::DATA_W-1:0] din_s2_q;
	logic [ante_pkg::NUM_WAIT-1:0] wait_s1_q;
	logic [ante_pkg::NUM_WAIT-1:0] wait_s2_q;
	logic [ante_pkg::ADDR_W-1:0] addr_q;
	logic addr_valid_q;
	logic [ante_pkg::BE_W-1:0] be_n_q;
	logic [ante_pkg::DATA_W-1:0] dout_q;
	logic dout_oe_q;
	logic [ante_pkg::SEL_W-1:0] sel_q;
	logic rd_valid_q;
	logic [ante_pkg::DATA_W-1:0] rd_data_q;
	logic take_q;

	wire in_access = (state_q == ante_pkg::ANTE_ACCESS);
	wire in_gap = (state_q == ante_pkg::ANTE_GAP);
	wire accept = req_valid && (state_q == ante_pkg::ANTE_IDLE);
	wire is_wr = req_q.write;
	// Scale wrap: with the scale bit set every unit lasts two cycles
	wire unit_wrap = (s_q == cfg.timing_scale_bit);
	wire unit_start = !s_q;
	wire [PW-1:0] ext = PW'(req_q.words_m1) * PW'(cfg.page_word_interval);
	wire [PW-1:0] cs_on = PW'(cfg.select_assert_count);
	wire [PW-1:0] cs_off = (is_wr ? PW'(cfg.select_write_release_count)
		: PW'(cfg.select_read_release_count)) + ext;
	wire [PW-1:0] lat_on = PW'(cfg.latch_assert_count);
	wire [PW-1:0] lat_off = is_wr ? PW'(cfg.latch_write_release_count)
		: PW'(cfg.latch_read_release_count);
	wire [PW-1:0] rs_on = PW'(cfg.read_strobe_assert_count);
	wire [PW-1:0] rs_off = PW'(cfg.read_strobe_release_count) + ext;
	wire [PW-1:0] ws_on = PW'(cfg.write_strobe_assert_count);
	wire [PW-1:0] ws_off = PW'(cfg.write_strobe_release_count);
	wire [PW-1:0] cyc_len = (is_wr ? PW'(cfg.write_cycle_length)
		: PW'(cfg.read_cycle_length)) + ext;
	wire [PW-1:0] pbi = PW'(cfg.page_word_interval);
	// Zero length still runs one unit, so the machine cannot hang
	wire last_unit = (u_q + ante_pkg::POS_ONE) >= cyc_len;
	wire access_end = in_access && unit_wrap && last_unit;
	wire word_hit = in_access && unit_start && (u_q == next_q);
	wire rd_hit = word_hit && !is_wr;
	wire more_words = word_q < req_q.words_m1;
	wire advance = word_hit && more_words;
	wire cs_lvl = in_access && (u_q >= cs_on) && (u_q < cs_off);
	wire lat_lvl = in_access && (u_q >= lat_on) && (u_q < lat_off);
	wire rs_lvl = in_access && !is_wr && (u_q >= rs_on) && (u_q < rs_off);
	wire ws_lvl = in_access && is_wr && (u_q >= ws_on) && (u_q < ws_off);
	// Direction stays high through turnaround after a read
	wire dir_lvl = (rs_lvl || (in_access && !is_wr && u_q >= rs_on)) ||
		(in_gap && (ta_q != '0));
	wire gap_done = (gap_q <= ante_pkg::GAP_ONE) &&
		(ta_q <= ante_pkg::TA_ONE);
	wire [ante_pkg::NUM_CS-1:0] cs_onehot = ante_pkg::CS_ONE << sel_q;
	wire cs_act = cfg.select_half_cycle_shift ?
		stb_neg_q[ante_pkg::STB_CS] : stb_pos_q[ante_pkg::STB_CS];
	wire lat_act = cfg.latch_half_cycle_shift ?
		stb_neg_q[ante_pkg::STB_LATCH] : stb_pos_q[ante_pkg::STB_LATCH];
	wire rs_act = cfg.read_strobe_half_cycle_shift ?
		stb_neg_q[ante_pkg::STB_RD] : stb_pos_q[ante_pkg::STB_RD];
	wire ws_act = cfg.write_strobe_half_cycle_shift ?
		stb_neg_q[ante_pkg::STB_WR] : stb_pos_q[ante_pkg::STB_WR];
	// Rise follows read strobe shift, fall is not shifted
	wire dir_act = stb_pos_q[ante_pkg::STB_DIR] &&
		(stb_neg_q[ante_pkg::STB_DIR] || !cfg.read_strobe_half_cycle_shift);

	always_comb
	begin
		stb_d = '0;
		stb_d[ante_pkg::STB_CS] = cs_lvl;
		stb_d[ante_pkg::STB_LATCH] = lat_lvl;
		stb_d[ante_pkg::STB_RD] = rs_lvl;
		stb_d[ante_pkg::STB_WR] = ws_lvl;
		stb_d[ante_pkg::STB_DIR] = dir_lvl;
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ante_pkg::ANTE_IDLE:
			begin
				if (accept)
					state_d = ante_pkg::ANTE_ACCESS;
			end
			ante_pkg::ANTE_ACCESS:
			begin
				if (access_end)
				begin
					if ((cfg.inter_access_gap != '0) ||
						(!is_wr && cfg.turnaround_count != '0))
						state_d = ante_pkg::ANTE_GAP;
					else
						state_d = ante_pkg::ANTE_IDLE;
				end
			end
			ante_pkg::ANTE_GAP:
			begin
				if (gap_done)
					state_d = ante_pkg::ANTE_IDLE;
			end
			default:
				state_d = ante_pkg::ANTE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			state_q <= ante_pkg::ANTE_IDLE;
		else
			state_q <= state_d;
	end

	// Position counters, reset at every cycle start
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !in_access)
		begin
			u_q <= '0;
			s_q <= 1'b0;
		end
		else if (unit_wrap)
		begin
			u_q <= u_q + ante_pkg::POS_ONE;
			s_q <= 1'b0;
		end
		else
			s_q <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			req_q <= '0;
			word_q <= '0;
			next_q <= '0;
		end
		else if (accept)
		begin
			req_q <= req;
			word_q <= '0;
			next_q <= req.write ? PW'(cfg.write_strobe_release_count)
				: PW'(cfg.sample_delay_count);
		end
		else if (advance)
		begin
			word_q <= word_q + ante_pkg::WORD_ONE;
			next_q <= next_q + pbi;
			if (is_wr)
				req_q.wdata <= burst_wdata;
		end
	end

	// Gap is unscaled; turnaround only follows reads
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			gap_q <= '0;
			ta_q <= '0;
		end
		else if (access_end)
		begin
			gap_q <= cfg.inter_access_gap;
			ta_q <= is_wr ? '0 : cfg.turnaround_count;
		end
		else if (in_gap)
		begin
			gap_q <= (gap_q != '0) ? gap_q - ante_pkg::GAP_ONE : '0;
			ta_q <= (ta_q != '0) ? ta_q - ante_pkg::TA_ONE : '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			stb_pos_q <= '0;
		else
			stb_pos_q <= stb_d;
	end

	// Half-cycle copies for the extra-delay options
	always_ff @(negedge sys_clk)
	begin
		if (!rst_n)
			stb_neg_q <= '0;
		else
			stb_neg_q <= stb_pos_q;
	end

	// Address and lanes valid from cycle start, invalid in gaps
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !in_access)
		begin
			addr_q <= ante_pkg::ADDR_ZERO;
			addr_valid_q <= 1'b0;
			be_n_q <= '1;
			dout_q <= '0;
			dout_oe_q <= 1'b0;
		end
		else
		begin
			addr_q <= req_q.addr + ante_pkg::ADDR_W'(word_q);
			addr_valid_q <= 1'b1;
			be_n_q <= req_q.be_n;
			dout_q <= req_q.wdata;
			dout_oe_q <= is_wr;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			sel_q <= '0;
		else if (accept)
			sel_q <= req.sel;
	end

	// Pins pass two stages; sample strobe delayed to match
	always_ff @(posedge sys_clk)
	begin
		din_s1_q <= mem_din;
		din_s2_q <= din_s1_q;
		wait_s1_q <= mem_wait_in;
		wait_s2_q <= wait_s1_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			samp_pipe_q <= '0;
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
			take_q <= 1'b0;
		end
		else
		begin
			samp_pipe_q <= {samp_pipe_q[ante_pkg::SAMPLE_PIPE-2:0], rd_hit};
			rd_valid_q <= samp_pipe_q[ante_pkg::SAMPLE_PIPE-1];
			if (samp_pipe_q[ante_pkg::SAMPLE_PIPE-1])
				rd_data_q <= din_s2_q;
			take_q <= advance && is_wr;
		end
	end

	assign req_ready = (state_q == ante_pkg::ANTE_IDLE);
	assign busy = !req_ready;
	assign wr_word_take = take_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign wait_level = wait_s2_q;
	assign mem_addr = addr_q;
	assign mem_addr_valid = addr_valid_q;
	assign mem_be_n = be_n_q;
	assign mem_dout = dout_q;
	assign mem_dout_oe = dout_oe_q;
	// Only strobes leave; the clock itself stays inside
	assign cs_n = ~(cs_act ? cs_onehot : '0);
	assign latch_n = !lat_act;
	assign rd_strobe_n = !rs_act;
	assign wr_strobe_n = !ws_act;
	assign io_dir = dir_act;
endmodule
`default_nettype wire

/* sim/ante_timing_engine_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module ante_te_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ante_pkg::ante_timing_s cfg,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire ante_pkg::ante_req_s req,
	input wire logic mem_addr_valid,
	input wire logic [ante_pkg::NUM_CS-1:0] cs_n,
	input wire logic latch_n,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	input wire logic io_dir
);
	logic [9:0] c_q, t_q, ext;
	logic [3:0] v_q;
	logic w_q, ns, hi;
	logic [2:0] n_q;
	logic [1:0] k;
	assign k = {1'b0, cfg.timing_scale_bit} + 2'h1;
	assign hi = &cs_n;
	// Shift bits; half-cycle edges are not judged here
	assign ns = ~|cfg[11:8];
	assign ext = 10'(n_q) * 10'(cfg.page_word_interval);
	always_ff @(posedge sys_clk)
	begin
		c_q <= hi ? 10'h000 : c_q + 10'h001;
		t_q <= (req_valid && req_ready) ? 10'h001 : t_q + 10'h001;
		v_q <= (!rst_n) ? 4'hf : (mem_addr_valid ? 4'h0 : v_q + 4'(v_q != 4'hf));
		if (req_valid && req_ready)
		begin
			w_q <= req.write;
			n_q <= req.words_m1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_SEL_ON: assert property ($fell(hi) && ns |-> mem_addr_valid && t_q == 10'h002 + cfg.select_assert_count * k) else $error("select asserted at wrong time");
	AST_ONE_SEL: assert property (hi || $onehot(~cs_n)) else $error("more than one select low");
	AST_SEL_LEN: assert property ($rose(hi) && ns |-> c_q == ((w_q ? cfg.select_write_release_count : cfg.select_read_release_count) - cfg.select_assert_count + ext) * k) else $error("select width wrong");
	AST_LAT_ON: assert property ($fell(latch_n) && ns |-> c_q == (cfg.latch_assert_count - cfg.select_assert_count) * k) else $error("latch assert wrong");
	AST_LAT_OFF: assert property ($rose(latch_n) && ns |-> c_q == ((w_q ? cfg.latch_write_release_count : cfg.latch_read_release_count) - cfg.select_assert_count) * k) else $error("latch release wrong");
	AST_RD_ON: assert property ($fell(rd_strobe_n) && ns |-> io_dir && c_q == (cfg.read_strobe_assert_count - cfg.select_assert_count) * k) else $error("read strobe assert wrong");
	AST_RD_OFF: assert property ($rose(rd_strobe_n) && ns |-> c_q == (cfg.read_strobe_release_count - cfg.select_assert_count + ext) * k) else $error("read strobe release wrong");
	AST_WR_ON: assert property ($fell(wr_strobe_n) && ns |-> c_q == (cfg.write_strobe_assert_count - cfg.select_assert_count) * k) else $error("write strobe assert wrong");
	AST_WR_OFF: assert property ($rose(wr_strobe_n) && ns |-> c_q == (cfg.write_strobe_release_count - cfg.select_assert_count) * k) else $error("write strobe release wrong");
	AST_GAP: assert property ($rose(mem_addr_valid) |-> v_q >= cfg.inter_access_gap) else $error("address gap too short");
	cover property ($fell(rd_strobe_n));
	cover property ($fell(wr_strobe_n) && n_q == 3'h3);
	cover property ($fell(hi) && k == 2'h2);
endmodule
bind ante_timing_engine ante_te_asserts i_ante_te_asserts (.sys_clk, .rst_n,
	.cfg, .req_valid, .req_ready, .req, .mem_addr_valid, .cs_n, .latch_n,
	.rd_strobe_n, .wr_strobe_n, .io_dir);
`default_nettype wire

/* sim/ante_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ante_mem_model #(parameter int DLY = 0) (
	input wire logic sys_clk,
	input wire logic [ante_pkg::NUM_CS-1:0] cs_n,
	input wire logic rd_strobe_n,
	input wire logic [ante_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [ante_pkg::DATA_W-1:0] mem_dout,
	input wire logic mem_dout_oe,
	output logic [ante_pkg::DATA_W-1:0] mem_din,
	output logic [ante_pkg::NUM_WAIT-1:0] mem_wait_in
);
	logic [15:0] mem [256];
	logic [15:0] last = 16'h0000;
	logic [7:0] lo = 8'h00;
	logic drv;
	// Data only after DLY strobe cycles; otherwise the bus shows the inverse of the last driven word
	assign drv = !rd_strobe_n && !(&cs_n) && lo >= 8'(DLY);
	assign mem_din = drv ? mem[mem_addr[7:0]] : ~last;
	assign mem_wait_in = mem_addr[3:0] ^ 4'ha;
	always @(posedge sys_clk)
	begin
		lo <= rd_strobe_n ? 8'h00 : lo + 8'h01;
		if (drv)
			last <= mem_din;
		if (!(&cs_n) && mem_dout_oe)
			mem[mem_addr[7:0]] <= mem_dout;
	end
endmodule
`default_nettype wire

/* sim/ante_timing_engine_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module ante_timing_engine_bench;
	logic sys_clk, rst_n, req_valid, take_s;
	ante_pkg::ante_timing_s cfg;
	ante_pkg::ante_req_s req;
	logic [15:0] burst_wdata, rd_data, mem_din, mem_dout;
	logic [25:0] mem_addr;
	logic [7:0] cs_n;
	logic [3:0] wait_level, mem_wait_in;
	logic [1:0] mem_be_n;
	logic req_ready, wr_word_take, rd_valid, busy, mem_addr_valid;
	logic mem_dout_oe, latch_n, rd_strobe_n, wr_strobe_n, io_dir;
	int n_errors = 0;
	int num_checks = 0;
	logic [15:0] q[$];
	ante_timing_engine i_ante_timing_engine (.sys_clk, .rst_n, .cfg,
		.req_valid, .req_ready, .req, .burst_wdata, .wr_word_take, .rd_valid,
		.rd_data, .busy, .wait_level, .mem_addr, .mem_addr_valid, .mem_be_n,
		.mem_dout, .mem_dout_oe, .mem_din, .mem_wait_in, .cs_n, .latch_n,
		.rd_strobe_n, .wr_strobe_n, .io_dir);
	ante_mem_model #(.DLY(2)) i_ante_mem_model (.sys_clk, .cs_n, .rd_strobe_n,
		.mem_addr, .mem_dout, .mem_dout_oe, .mem_din, .mem_wait_in);
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Sampled mid-cycle so registered outputs have settled
	always @(negedge sys_clk)
	begin
		take_s = wr_word_take;
		if (rd_valid === 1'b1)
			q.push_back(rd_data);
	end
	always @(posedge sys_clk)
		if (take_s === 1'b1)
			burst_wdata <= burst_wdata + 16'h0101;
	task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [2:0] s,
		input logic [25:0] a, input logic [15:0] d, input logic [2:0] m);
		int i;
		i = 0;
		@(posedge sys_clk);
		req <= '{w, s, a, 2'h0, d, m};
		req_valid <= 1'b1;
		do @(negedge sys_clk); while (req_ready !== 1'b1 && ++i < 200);
		if (i >= 200)
		begin
			n_errors++;
			finish_test;
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
		do @(negedge sys_clk); while (busy !== 1'b0 && ++i < 400);
		if (i >= 400)
		begin
			n_errors++;
			finish_test;
		end
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic t_sel;
		logic [15:0] d;
		for (int s = 0; s < 8; s++)
			acc(1'b1, 3'(s), 26'(8'h10 + s), {4{1'b0, 3'(s)}}, 3'h0);
		for (int s = 0; s < 8; s++)
		begin
			d = {4{1'b0, 3'(s)}};
			acc(1'b0, 3'(s), 26'(8'h10 + s), 16'h0000, 3'h0);
			chk(26'(q.size()), 26'h1);
			chk(26'(q.pop_front()), 26'(d));
		end
		$display("select sweep done");
	endtask
	task automatic t_burst(input logic g);
		logic [25:0] a;
		a = g ? 26'h80 : 26'h40;
		@(posedge sys_clk);
		cfg.timing_scale_bit <= g;
		burst_wdata <= 16'h5a00;
		acc(1'b1, 3'h2, a, 16'h0a0a, 3'h3);
		acc(1'b0, 3'h2, a, 16'h0000, 3'h3);
		chk(26'(q.size()), 26'h4);
		chk(26'(q.pop_front()), 26'h0a0a);
		for (int j = 0; j < 3; j++)
			chk(26'(q.pop_front()), 26'(16'h5a00 + 16'h0101 * j));
		$display("burst done, scale %0d", g);
	endtask
	task automatic t_idle;
		chk({cs_n, latch_n, rd_strobe_n, wr_strobe_n, io_dir}, 26'hffe);
		chk(26'(wait_level), 26'ha);
		$display("idle check done");
	endtask
	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		burst_wdata = 16'h0000;
		cfg = '{5'h01, 5'h0a, 5'h0a, 5'h01, 5'h03, 5'h03, 5'h03, 5'h0a, 5'h03,
			5'h08, 5'h0b, 5'h0b, 5'h07, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
			4'h2, 4'h3};
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_sel;
		t_burst(1'b0);
		t_burst(1'b1);
		t_idle;
		finish_test;
	end
endmodule
`default_nettype wire
